// *** design/frt_params.svh ***
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

// Register byte addresses, one aligned word each
`define FRT_ADDR_CTL_TWO 8'h00
`define FRT_ADDR_CTL_ONE 8'h04
`define FRT_ADDR_STATUS 8'h08
`define FRT_ADDR_CAP1_HI 8'h0c
`define FRT_ADDR_CAP1_LO 8'h10
`define FRT_ADDR_CMP1_HI 8'h14
`define FRT_ADDR_CMP1_LO 8'h18
`define FRT_ADDR_CNT_HI 8'h1c
`define FRT_ADDR_CNT_LO 8'h20
`define FRT_ADDR_ACNT_HI 8'h24
`define FRT_ADDR_ACNT_LO 8'h28
`define FRT_ADDR_CAP2_HI 8'h2c
`define FRT_ADDR_CAP2_LO 8'h30
`define FRT_ADDR_CMP2_HI 8'h34
`define FRT_ADDR_CMP2_LO 8'h38

// Reset values and counter maximum
`define FRT_CTL_RESET 8'h00
`define FRT_CNT_RESET 16'hfffc
`define FRT_CMP_RESET 16'h8000
`define FRT_CNT_MAX 16'hffff

// Status bit positions
`define FRT_SR_CAP1 7
`define FRT_SR_CMP1 6
`define FRT_SR_OVF 5
`define FRT_SR_CAP2 4
`define FRT_SR_CMP2 3
`define FRT_SR_DIS 2

// Clock select codes
`define FRT_CC_DIV4 2'h0
`define FRT_CC_DIV2 2'h1
`define FRT_CC_DIV8 2'h2
`define FRT_CC_EXT 2'h3

`endif

// *** design/frt_pkg.sv ***
package frt_pkg;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic out_level_two;
    logic capture_one_edge;
    logic out_level_one;
  } frt_ctl_one_t;

  typedef struct packed {
    logic compare_one_pin_en;
    logic compare_two_pin_en;
    logic one_pulse_select;
    logic pwm_select;
    logic clock_select_high;
    logic clock_select_low;
    logic capture_two_edge;
    logic ext_clock_edge;
  } frt_ctl_two_t;

  // Flags in status bit order 7..3
  typedef struct packed {
    logic capture_one_flag;
    logic compare_one_flag;
    logic overflow_flag;
    logic capture_two_flag;
    logic compare_two_flag;
  } frt_flags_t;

  typedef struct packed {
    frt_ctl_one_t ctl1;
    frt_ctl_two_t ctl2;
    logic timer_disable;
    frt_flags_t flags;
    frt_flags_t clr_arm;
    logic [15:0] cnt;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic cmp1_inh;
    logic cmp2_inh;
    logic [2:0] presc;
    logic tick_seen;
    logic [2:0] cap1_s;
    logic [2:0] cap2_s;
    logic [2:0] ext_s;
    logic halt_arm1;
    logic halt_arm2;
    logic halt_prev;
    logic out1;
    logic out2;
    logic out1_en;
    logic out2_en;
    logic irq;
    logic wake;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } frt_state_t;

endpackage : frt_pkg

// *** design/frt_timer.sv ***
`timescale 1ns/1ps
`include "frt_params.svh"

// Contract
// R1: In Wait the timer runs on; an enabled timer interrupt requests wake-up.
// R2: Halt freezes the counter; interrupt wake resumes, reset restarts at reset value.
// R3: Capture edge in Halt arms; on wake set flag and capture counter.
// R4: Capture interrupt enable gates both capture flags onto the interrupt.
// R5: Compare interrupt enable gates compare flags; no compare events in PWM.
// R6: Overflow interrupt enable gates the overflow flag onto the interrupt.
// R7: Force level two copies out level two to pin two when enabled.
// R8: Force level one copies out level one to pin one when enabled.
// R9: Out level two goes to pin two on match, to pin one in pulse modes.
// R10: Capture one edge bit picks falling (0) or rising (1) trigger edge.
// R11: Out level one goes to pin one on compare one match.
// R12: Compare one pin enable only routes the pin; compare one stays active.
// R13: Compare two pin enable only routes the pin; compare two stays active.
// R14: One pulse select: capture one edge starts a pulse sized by compare one.
// R15: PWM: pulse from compare one, period from compare two, on pin one.
// R16: Clock select: 00 div4, 01 div2, 10 div8, 11 external pin.
// R17: Without an external pin, external selection stops the counter.
// R18: Capture two edge bit picks falling (0) or rising (1) trigger edge.
// R19: External edge bit picks which external pin edge advances the counter.
// R20: Capture flags set on capture or PWM period; clear by status read, low access.
// R21: Compare flags set on match; clear by status read, compare low access.
// R22: Overflow flag sets on wrap; clear via counter low, not alt counter low.
// R23: Timer disable freezes prescaler and counter, disables both outputs.
// R24: A flag event coinciding with its clear leaves the flag set.
module frt_timer #(
  parameter bit EXT_PIN_PRESENT = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic capture_in_one,
  input wire logic capture_in_two,
  input wire logic external_count_pin,
  output logic compare_out_one,
  output logic compare_out_one_en,
  output logic compare_out_two,
  output logic compare_out_two_en,
  output logic timer_irq,
  output logic wait_wake_req
);

  frt_pkg::frt_state_t s_ff;
  frt_pkg::frt_state_t nxt_s;

  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_hit

  function automatic logic div_hit(input logic [1:0] cc, input logic [2:0] presc);
    unique case (cc)
      `FRT_CC_DIV4: div_hit = (presc[1:0] == 2'h3);
      `FRT_CC_DIV2: div_hit = presc[0];
      `FRT_CC_DIV8: div_hit = (presc == 3'h7);
      `FRT_CC_EXT: div_hit = 1'b0;
    endcase
  endfunction : div_hit

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction : byte_word

  logic [1:0] cc;
  logic run;
  logic tick;
  logic cap1_edge;
  logic cap2_edge;
  logic ext_edge;
  logic match1;
  logic match2;
  logic pwm_on;
  logic opm_on;
  logic halt_exit;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [31:0] rd_val;
  logic [7:0] wb;
  frt_pkg::frt_flags_t ev;
  frt_pkg::frt_flags_t clr;

  always_comb begin
    nxt_s = s_ff;
    cc = {s_ff.ctl2.clock_select_high, s_ff.ctl2.clock_select_low};
    pwm_on = s_ff.ctl2.pwm_select;
    opm_on = s_ff.ctl2.one_pulse_select & ~pwm_on;
    wb = pwdata[7:0];
    ev = '0;
    clr = '0;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    nxt_s.cap1_s = {s_ff.cap1_s[1:0], capture_in_one};
    nxt_s.cap2_s = {s_ff.cap2_s[1:0], capture_in_two};
    nxt_s.ext_s = {s_ff.ext_s[1:0], external_count_pin};
    cap1_edge = edge_hit(s_ff.cap1_s[2], s_ff.cap1_s[1], s_ff.ctl1.capture_one_edge); // R10
    cap2_edge = edge_hit(s_ff.cap2_s[2], s_ff.cap2_s[1], s_ff.ctl2.capture_two_edge); // R18
    ext_edge = edge_hit(s_ff.ext_s[2], s_ff.ext_s[1], s_ff.ctl2.ext_clock_edge); // R19

    // ****************************************
    // Prescaler and counter
    // ****************************************
    // Wait mode is deliberately not looked at here
    run = ~s_ff.timer_disable & ~halt_mode; // R1 R2 R23
    if (cc == `FRT_CC_EXT) begin
      tick = run & EXT_PIN_PRESENT & ext_edge; // R16 R17
    end else begin
      tick = run & div_hit(cc, s_ff.presc); // R16
    end
    if (~s_ff.timer_disable) begin
      nxt_s.presc = s_ff.presc + 3'h1; // R23
    end
    nxt_s.tick_seen = tick;
    if (tick) begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
      ev.overflow_flag = (s_ff.cnt == `FRT_CNT_MAX); // R22
    end

    // Match only on the cycle after the counter moved into equality
    match1 = s_ff.tick_seen & ~s_ff.cmp1_inh & (s_ff.cnt == s_ff.cmp1);
    match2 = s_ff.tick_seen & ~s_ff.cmp2_inh & (s_ff.cnt == s_ff.cmp2);

    // ****************************************
    // Capture, compare and waveform modes
    // ****************************************
    halt_exit = s_ff.halt_prev & ~halt_mode;
    nxt_s.halt_prev = halt_mode;
    if (halt_mode) begin
      // Edges in Halt are only remembered
      nxt_s.halt_arm1 = s_ff.halt_arm1 | (cap1_edge & ~pwm_on & ~opm_on); // R3
      nxt_s.halt_arm2 = s_ff.halt_arm2 | cap2_edge; // R3
    end else begin
      nxt_s.halt_arm1 = 1'b0;
      nxt_s.halt_arm2 = 1'b0;
      if (halt_exit && s_ff.halt_arm1) begin
        nxt_s.cap1 = s_ff.cnt; // R3
        ev.capture_one_flag = 1'b1; // R3
      end
      if (halt_exit && s_ff.halt_arm2) begin
        nxt_s.cap2 = s_ff.cnt; // R3
        ev.capture_two_flag = 1'b1; // R3
      end
      if (cap2_edge) begin
        nxt_s.cap2 = s_ff.cnt;
        ev.capture_two_flag = 1'b1; // R20
      end
    end

    if (pwm_on) begin
      if (match1) begin
        nxt_s.out1 = s_ff.ctl1.out_level_one; // R15
      end
      if (match2) begin
        nxt_s.out1 = s_ff.ctl1.out_level_two; // R9 R15
        nxt_s.cnt = `FRT_CNT_RESET; // R15
        ev.capture_one_flag = 1'b1; // R20
      end
    end else if (opm_on) begin
      if (cap1_edge && !halt_mode) begin
        nxt_s.cap1 = s_ff.cnt; // R14
        nxt_s.cnt = `FRT_CNT_RESET; // R14
        nxt_s.out1 = s_ff.ctl1.out_level_two; // R9 R14
        ev.capture_one_flag = 1'b1; // R20
      end else if (match1) begin
        nxt_s.out1 = s_ff.ctl1.out_level_one; // R14
      end
      ev.compare_two_flag = match2; // R21
    end else begin
      if (cap1_edge && !halt_mode) begin
        nxt_s.cap1 = s_ff.cnt;
        ev.capture_one_flag = 1'b1; // R20
      end
      ev.compare_one_flag = match1; // R5 R12 R21
      ev.compare_two_flag = match2; // R5 R13 R21
      if (match1 || s_ff.ctl1.force_level_one) begin
        nxt_s.out1 = s_ff.ctl1.out_level_one; // R8 R11
      end
      if (match2 || s_ff.ctl1.force_level_two) begin
        nxt_s.out2 = s_ff.ctl1.out_level_two; // R7 R9
      end
    end
    nxt_s.out1_en = s_ff.ctl2.compare_one_pin_en & ~s_ff.timer_disable; // R12 R23
    nxt_s.out2_en = s_ff.ctl2.compare_two_pin_en & ~s_ff.timer_disable; // R13 R23

    // ****************************************
    // APB slave
    // ****************************************
    // One wait state: pready rises in the second access cycle
    done = psel & penable & s_ff.pready;
    wr_done = done & pwrite;
    rd_done = done & ~pwrite;
    nxt_s.pready = psel & penable & ~s_ff.pready;
    mapped = 1'b1;
    unique case (paddr)
      `FRT_ADDR_CTL_TWO: rd_val = byte_word(s_ff.ctl2);
      `FRT_ADDR_CTL_ONE: rd_val = byte_word(s_ff.ctl1);
      `FRT_ADDR_STATUS: rd_val = byte_word({s_ff.flags, s_ff.timer_disable, 2'h0});
      `FRT_ADDR_CAP1_HI: rd_val = byte_word(s_ff.cap1[15:8]);
      `FRT_ADDR_CAP1_LO: rd_val = byte_word(s_ff.cap1[7:0]);
      `FRT_ADDR_CMP1_HI: rd_val = byte_word(s_ff.cmp1[15:8]);
      `FRT_ADDR_CMP1_LO: rd_val = byte_word(s_ff.cmp1[7:0]);
      `FRT_ADDR_CNT_HI: rd_val = byte_word(s_ff.cnt[15:8]);
      `FRT_ADDR_CNT_LO: rd_val = byte_word(s_ff.cnt[7:0]);
      `FRT_ADDR_ACNT_HI: rd_val = byte_word(s_ff.cnt[15:8]);
      `FRT_ADDR_ACNT_LO: rd_val = byte_word(s_ff.cnt[7:0]);
      `FRT_ADDR_CAP2_HI: rd_val = byte_word(s_ff.cap2[15:8]);
      `FRT_ADDR_CAP2_LO: rd_val = byte_word(s_ff.cap2[7:0]);
      `FRT_ADDR_CMP2_HI: rd_val = byte_word(s_ff.cmp2[15:8]);
      `FRT_ADDR_CMP2_LO: rd_val = byte_word(s_ff.cmp2[7:0]);
      default: begin
        rd_val = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
    if (psel && penable && !s_ff.pready) begin
      nxt_s.prdata = pwrite ? 32'h00000000 : rd_val;
      nxt_s.pslverr = ~mapped;
    end else begin
      nxt_s.prdata = 32'h00000000;
      nxt_s.pslverr = 1'b0;
    end

    if (rd_done && paddr == `FRT_ADDR_STATUS) begin
      nxt_s.clr_arm = s_ff.flags; // R20 R21 R22
    end
    if (done) begin
      clr.capture_one_flag = s_ff.clr_arm.capture_one_flag & (paddr == `FRT_ADDR_CAP1_LO);
      clr.compare_one_flag = s_ff.clr_arm.compare_one_flag & (paddr == `FRT_ADDR_CMP1_LO);
      clr.overflow_flag = s_ff.clr_arm.overflow_flag & (paddr == `FRT_ADDR_CNT_LO); // R22
      clr.capture_two_flag = s_ff.clr_arm.capture_two_flag & (paddr == `FRT_ADDR_CAP2_LO);
      clr.compare_two_flag = s_ff.clr_arm.compare_two_flag & (paddr == `FRT_ADDR_CMP2_LO);
      nxt_s.clr_arm = nxt_s.clr_arm & ~clr;
    end

    if (wr_done) begin
      unique case (paddr)
        `FRT_ADDR_CTL_TWO: nxt_s.ctl2 = wb;
        `FRT_ADDR_CTL_ONE: nxt_s.ctl1 = wb;
        `FRT_ADDR_STATUS: nxt_s.timer_disable = wb[`FRT_SR_DIS]; // R23
        `FRT_ADDR_CMP1_HI: begin
          nxt_s.cmp1[15:8] = wb;
          nxt_s.cmp1_inh = 1'b1;
        end
        `FRT_ADDR_CMP1_LO: begin
          nxt_s.cmp1[7:0] = wb;
          nxt_s.cmp1_inh = 1'b0;
        end
        `FRT_ADDR_CMP2_HI: begin
          nxt_s.cmp2[15:8] = wb;
          nxt_s.cmp2_inh = 1'b1;
        end
        `FRT_ADDR_CMP2_LO: begin
          nxt_s.cmp2[7:0] = wb;
          nxt_s.cmp2_inh = 1'b0;
        end
        `FRT_ADDR_CNT_LO, `FRT_ADDR_ACNT_LO: nxt_s.cnt = `FRT_CNT_RESET;
        default: nxt_s.cnt = nxt_s.cnt;
      endcase
    end

    // ****************************************
    // Flags and interrupt
    // ****************************************
    // Set beats clear so a coincident event survives
    nxt_s.flags = ev | (s_ff.flags & ~clr); // R24
    nxt_s.irq = (s_ff.ctl1.capture_irq_enable
                 & (nxt_s.flags.capture_one_flag | nxt_s.flags.capture_two_flag)) // R4
              | (s_ff.ctl1.compare_irq_enable
                 & (nxt_s.flags.compare_one_flag | nxt_s.flags.compare_two_flag)) // R5
              | (s_ff.ctl1.overflow_irq_enable & nxt_s.flags.overflow_flag); // R6
    nxt_s.wake = nxt_s.irq & wait_mode; // R1
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.cnt <= `FRT_CNT_RESET; // R2
      s_ff.cmp1 <= `FRT_CMP_RESET;
      s_ff.cmp2 <= `FRT_CMP_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign compare_out_one = s_ff.out1;
  assign compare_out_one_en = s_ff.out1_en;
  assign compare_out_two = s_ff.out2;
  assign compare_out_two_en = s_ff.out2_en;
  assign timer_irq = s_ff.irq;
  assign wait_wake_req = s_ff.wake;

endmodule : frt_timer

// *** verif/frt_assertions.sv ***
`timescale 1ns/1ps
// ********************
// Port-level checks
// ********************
module frt_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_mode,
  input wire logic compare_out_one_en,
  input wire logic compare_out_two_en,
  input wire logic timer_irq,
  input wire logic wait_wake_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late bus answer");
  a_ready_single: assert property (pready |=> !pready) else $error("long bus answer");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("answer without access");
  a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h38))
    else $error("wrong error flag");
  a_read_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_read_byte: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_wait_wake: assert property (wait_wake_req == (timer_irq && $past(wait_mode)))
    else $error("wake request wrong");
  // Pin ownership moves only after a register write lands
  a_pin_one_owner: assert property ($changed(compare_out_one_en) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("pin one owner");
  a_pin_two_owner: assert property ($changed(compare_out_two_en) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("pin two owner");
  c_irq: cover property ($rose(timer_irq));
  c_wake: cover property (wait_wake_req);
  c_err: cover property (pready && pslverr);
endmodule : frt_chk

// *** verif/frt_pins.sv ***
`timescale 1ns/1ps
module frt_pins (
  input wire logic mclk,
  output logic capture_in_one,
  output logic capture_in_two,
  output logic external_count_pin
);
  // Count pin stands still except while a burst of pulses is sent
  initial begin
    capture_in_one = 1'b0;
    capture_in_two = 1'b0;
    external_count_pin = 1'b0;
  end
  task automatic drive(input bit two, input logic lvl);
    @(posedge mclk);
    if (two) begin
      capture_in_two <= lvl;
    end else begin
      capture_in_one <= lvl;
    end
  endtask : drive
  task automatic clk_ext(input int n);
    repeat (n) begin
      @(posedge mclk);
      external_count_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      external_count_pin <= 1'b0;
      @(posedge mclk);
    end
  endtask : clk_ext
endmodule : frt_pins

// *** verif/free_running_capture_compare_timer_tb.sv ***
`timescale 1ns/1ps
module free_running_capture_compare_timer_tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } frt_row_t;
  // Status first: the first wrap comes some 16 cycles after reset
  frt_row_t rows [16] = '{
    '{1'h0, 8'h08, 8'h00, 8'h00, 1'h0}, '{1'h0, 8'h04, 8'h00, 8'h00, 1'h0},
    '{1'h0, 8'h00, 8'h00, 8'h00, 1'h0}, '{1'h0, 8'h14, 8'h00, 8'h80, 1'h0},
    '{1'h0, 8'h38, 8'h00, 8'h00, 1'h0}, '{1'h0, 8'h0c, 8'h00, 8'h00, 1'h0},
    '{1'h1, 8'h04, 8'ha5, 8'h00, 1'h0}, '{1'h0, 8'h04, 8'h00, 8'ha5, 1'h0},
    '{1'h1, 8'h08, 8'hff, 8'h00, 1'h0}, '{1'h0, 8'h08, 8'h00, 8'h24, 1'h0},
    '{1'h1, 8'h08, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h10, 8'hff, 8'h00, 1'h0},
    '{1'h0, 8'h10, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h3c, 8'hff, 8'h00, 1'h1},
    '{1'h0, 8'h3c, 8'h00, 8'h00, 1'h1}, '{1'h1, 8'h04, 8'h00, 8'h00, 1'h0}};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wait_mode = 1'b0, halt_mode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, capture_in_one, capture_in_two, external_count_pin, timer_irq;
  logic compare_out_one, compare_out_one_en, compare_out_two, compare_out_two_en;
  logic wait_wake_req, err;
  logic [7:0] rd, rd2;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  frt_timer dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wait_mode, .halt_mode, .capture_in_one, .capture_in_two,
    .external_count_pin, .compare_out_one, .compare_out_one_en, .compare_out_two,
    .compare_out_two_en, .timer_irq, .wait_wake_req);
  frt_pins pins (.mclk, .capture_in_one, .capture_in_two, .external_count_pin);
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    chk("pready", pready, 8'h01);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, x);
  endtask : rc
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step
  task automatic wait_irq();
    int n;
    n = 0;
    while (timer_irq !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_irq
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (compare_out_one !== lvl && n < 200) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_pin
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // ********************
  // Main sequence
  // ********************
  initial begin
    step(4);
    sys_rst <= 1'b0;
    step(1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("register", rd, rows[i].x);
      chk("slave error", err, rows[i].e);
    end
    apb(1'b1, 8'h00, 8'h04);
    apb(1'b1, 8'h04, 8'h20);
    step(3);
    chk("irq", timer_irq, 8'h01);
    wait_mode <= 1'b1;
    step(3);
    chk("wake", wait_wake_req, 8'h01);
    wait_mode <= 1'b0;
    apb(1'b1, 8'h04, 8'h00);
    step(3);
    chk("irq", timer_irq, 8'h00);
    rc("status", 8'h08, 8'h20);
    apb(1'b0, 8'h28, 8'h00);
    rc("status", 8'h08, 8'h20);
    apb(1'b0, 8'h20, 8'h00);
    rc("status", 8'h08, 8'h00);
    apb(1'b1, 8'h14, 8'h00);
    apb(1'b1, 8'h18, 8'h80);
    apb(1'b1, 8'h04, 8'h40);
    wait_irq();
    chk("irq", timer_irq, 8'h01);
    rc("status", 8'h08, 8'h40);
    apb(1'b0, 8'h18, 8'h00);
    rc("status", 8'h08, 8'h00);
    apb(1'b1, 8'h04, 8'h82);
    pins.drive(1'b0, 1'b1);
    wait_irq();
    rc("status", 8'h08, 8'h80);
    pins.drive(1'b1, 1'b1);
    step(12);
    rc("status", 8'h08, 8'h80);
    pins.drive(1'b1, 1'b0);
    step(12);
    rc("status", 8'h08, 8'h90);
    apb(1'b1, 8'h00, 8'hc4);
    apb(1'b1, 8'h04, 8'h1d);
    step(3);
    chk("pins", {compare_out_one, compare_out_two, compare_out_one_en, compare_out_two_en},
      8'h0f);
    apb(1'b1, 8'h04, 8'h18);
    step(3);
    chk("pins", {compare_out_one, compare_out_two, compare_out_one_en, compare_out_two_en},
      8'h03);
    apb(1'b1, 8'h08, 8'h04);
    step(3);
    chk("pin owners", {compare_out_one_en, compare_out_two_en}, 8'h00);
    apb(1'b1, 8'h08, 8'h00);
    halt_mode <= 1'b1;
    apb(1'b0, 8'h20, 8'h00);
    rd2 = rd;
    step(10);
    rc("count", 8'h20, rd2);
    halt_mode <= 1'b0;
    sys_rst <= 1'b1;
    step(4);
    sys_rst <= 1'b0;
    step(1);
    rc("control one", 8'h04, 8'h00);
    rc("count high", 8'h1c, 8'hff);
    rc("status", 8'h08, 8'h00);
    // Capture edge during Halt is only armed until wake-up
    apb(1'b1, 8'h00, 8'h02);
    halt_mode <= 1'b1;
    pins.drive(1'b1, 1'b1);
    step(6);
    apb(1'b0, 8'h20, 8'h00);
    rd2 = rd;
    halt_mode <= 1'b0;
    step(3);
    rc("capture two", 8'h30, rd2);
    rc("status", 8'h08, 8'h30);
    // One pulse: mode first so the new compare value raises no flag
    apb(1'b1, 8'h04, 8'h04);
    apb(1'b1, 8'h00, 8'ha4);
    apb(1'b1, 8'h14, 8'h00);
    apb(1'b1, 8'h18, 8'h04);
    pins.drive(1'b0, 1'b0);
    wait_pin(1'b1);
    chk("pulse start", compare_out_one, 8'h01);
    wait_pin(1'b0);
    chk("pulse end", compare_out_one, 8'h00);
    rc("status", 8'h08, 8'hb0);
    // PWM: period from compare two, no compare flags
    apb(1'b1, 8'h00, 8'h94);
    apb(1'b1, 8'h34, 8'h00);
    apb(1'b1, 8'h38, 8'h10);
    apb(1'b1, 8'h20, 8'h00);
    wait_pin(1'b1);
    chk("period end", compare_out_one, 8'h01);
    wait_pin(1'b0);
    chk("duty end", compare_out_one, 8'h00);
    rc("status", 8'h08, 8'hb0);
    // External clock, rising edges only
    apb(1'b1, 8'h00, 8'h0d);
    apb(1'b1, 8'h20, 8'h00);
    pins.clk_ext(3);
    step(6);
    rc("external count", 8'h20, 8'hff);
    end_of_test();
  end
endmodule : free_running_capture_compare_timer_tb
bind frt_timer frt_chk u_chk (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .wait_mode, .compare_out_one_en, .compare_out_two_en, .timer_irq,
  .wait_wake_req);
